//--- dsd_pkg.sv
// package: register map, field layout and glyph table of the drive status display encoder
package dsd_pkg;

    // apb register byte addresses
    localparam logic [7:0] DSD_ADDR_STATUS = 8'h00;  // running_status_word, read only
    localparam logic [7:0] DSD_ADDR_CTRL   = 8'h04;  // view and display mode
    localparam logic [7:0] DSD_ADDR_LEDS   = 8'h08;  // four digit segment image, read only
    localparam logic [7:0] DSD_ADDR_TERM   = 8'h0C;  // terminal level word, read only

    // control register fields and reset values
    localparam int         DSD_CTRL_VIEW_POS = 0;  // 0 running status, 1 terminal check
    localparam int         DSD_CTRL_HEX_POS  = 1;  // terminal check: 0 segments, 1 hex
    localparam logic [1:0] DSD_CTRL_RESET    = 2'h0;

    // running status word bit positions
    localparam int DSD_ST_BUSY   = 15;
    localparam int DSD_ST_ZERO14 = 14;
    localparam int DSD_ST_ZERO13 = 13;
    localparam int DSD_ST_COMMS  = 12;
    localparam int DSD_ST_ALARM  = 11;
    localparam int DSD_ST_DECEL  = 10;
    localparam int DSD_ST_ACCEL  = 9;
    localparam int DSD_ST_ILIM   = 8;
    localparam int DSD_ST_VCTL   = 7;
    localparam int DSD_ST_ZERO6  = 6;
    localparam int DSD_ST_LINKOK = 5;
    localparam int DSD_ST_ZERO4  = 4;
    localparam int DSD_ST_SHUT   = 3;
    localparam int DSD_ST_BRAKE  = 2;
    localparam int DSD_ST_REV    = 1;
    localparam int DSD_ST_FWD    = 0;

    // terminal level word layout
    localparam int DSD_TW_INPUTS = 0;  // five input terminals, bits 4..0
    localparam int DSD_TW_COMM   = 5;  // comm forward, backward, reset, bits 7..5
    localparam int DSD_TW_RELAY  = 8;

    // segment positions inside a digit byte
    localparam int DSD_SEG_A  = 0;
    localparam int DSD_SEG_F  = 5;
    localparam int DSD_SEG_G  = 6;
    localparam int DSD_SEG_DP = 7;

    localparam logic [7:0]  DSD_SEG_DARK  = 8'h00;
    localparam logic [15:0] DSD_WORD_ZERO = 16'h0000;

    // hexadecimal glyphs, bit 0 = segment a .. bit 6 = segment g
    localparam logic [15:0][7:0] DSD_GLYPH = {
        8'h71, 8'h79, 8'h5E, 8'h39, 8'h7C, 8'h77, 8'h6F, 8'h7F,
        8'h07, 8'h7D, 8'h6D, 8'h66, 8'h4F, 8'h5B, 8'h06, 8'h3F
    };

    typedef enum logic { DSD_VIEW_STATUS, DSD_VIEW_TERMINAL } dsd_view_t;
    typedef enum logic { DSD_DISP_SEGMENT, DSD_DISP_HEX } dsd_disp_t;

endpackage : dsd_pkg

//--- dsd_digit_fmt.sv
// one led digit: hex glyph of a nibble or a direct segment image
`timescale 1ns/1ps
`default_nettype none
module dsd_digit_fmt
    import dsd_pkg::*;
(
    // digit source
    input  wire logic [3:0] nibble,
    input  wire logic       hex_mode,
    input  wire logic [7:0] seg_in,
    // segment byte
    output logic      [7:0] seg_out
);

    // glyph lookup when hex, else the terminal segment image passes through
    always_comb begin
        if (hex_mode) begin
            seg_out = DSD_GLYPH[nibble];
        end else begin
            seg_out = seg_in;
        end
    end

endmodule : dsd_digit_fmt
`default_nettype wire

//--- dsd_status_display.sv
// drive status display encoder: status word assembly, led digit formatting, apb slave
//
// Notes on behaviour
// - bit 15 is set while parameter data is being written.
// - bit 12 is set while run and frequency commands come over comms.
// - bit 11 is set while an alarm is present.
// - bit 10 decelerating, bit 9 accelerating, bit 8 current limiting.
// - bit 7 is set under voltage control.
// - bit 5 set when link voltage reached, clear on undervoltage.
// - bit 3 is set while the power output stage is shut down.
// - bit 2 is set while dc braking is applied.
// - bit 0 forward run, bit 1 reverse run.
// - hex shows four nibbles, leftmost bits 15..12, rightmost bits 3..0.
// - each nibble becomes its hex glyph 0..9 then A..F.
// - segment mode, rightmost digit a..e show the five input terminals.
// - segment mode, third digit segment a shows the transistor output closed.
// - segment mode, leftmost digit segment a shows relay common-to-open closed.
// - segments follow physical terminal levels, not logical function state.
// - up and down keys toggle segment and hex for the terminal check.
`timescale 1ns/1ps
`default_nettype none
module dsd_status_display
    import dsd_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // internal drive state
    input  wire logic        param_write_busy,
    input  wire logic        comms_control_active,
    input  wire logic        alarm_flag,
    input  wire logic        slowing_down,
    input  wire logic        speeding_up,
    input  wire logic        current_limiting,
    input  wire logic        voltage_control_active,
    input  wire logic        link_voltage_ok,
    input  wire logic        output_shutdown,
    input  wire logic        dc_braking_active,
    input  wire logic        forward_run,
    input  wire logic        backward_run,
    // physical terminal levels, high = closed to its common
    input  wire logic        forward_terminal,
    input  wire logic        backward_terminal,
    input  wire logic        digital_input_one,
    input  wire logic        digital_input_two,
    input  wire logic        digital_input_three,
    input  wire logic        transistor_output,
    input  wire logic        relay_normally_open,
    // commands received over the comms link
    input  wire logic        comm_forward_cmd,
    input  wire logic        comm_backward_cmd,
    input  wire logic        comm_reset_cmd,
    // keypad keys, one-cycle pulses
    input  wire logic        key_up,
    input  wire logic        key_down,
    // led digits, bit 0 = a .. bit 6 = g, bit 7 = dp
    output logic      [7:0]  led_digit_1,
    output logic      [7:0]  led_digit_2,
    output logic      [7:0]  led_digit_3,
    output logic      [7:0]  led_digit_4
);

    typedef struct packed {
        logic [15:0]     status;
        dsd_view_t       view;
        dsd_disp_t       disp;
        logic [3:0][7:0] digits;
        logic [31:0]     rdata;
    } dsd_state_t;

    dsd_state_t       st_r;
    dsd_state_t       st_nxt;
    logic [15:0]      stat_w;
    logic [15:0]      term_w;
    logic [15:0]      shown_w;
    logic             show_hex;
    logic [3:0][7:0]  seg_map;
    logic [3:0][7:0]  fmt_out;
    logic             apb_setup;
    logic             apb_access;
    logic             addr_ok;

    // running status word assembled from the live drive flags
    always_comb begin
        stat_w                = DSD_WORD_ZERO;
        stat_w[DSD_ST_BUSY]   = param_write_busy;
        stat_w[DSD_ST_COMMS]  = comms_control_active;
        stat_w[DSD_ST_ALARM]  = alarm_flag;
        stat_w[DSD_ST_DECEL]  = slowing_down;
        stat_w[DSD_ST_ACCEL]  = speeding_up;
        stat_w[DSD_ST_ILIM]   = current_limiting;
        stat_w[DSD_ST_VCTL]   = voltage_control_active;
        stat_w[DSD_ST_LINKOK] = link_voltage_ok;
        stat_w[DSD_ST_SHUT]   = output_shutdown;
        stat_w[DSD_ST_BRAKE]  = dc_braking_active;
        stat_w[DSD_ST_FWD]    = forward_run;
        stat_w[DSD_ST_REV]    = backward_run;
    end

    // terminal word: raw pin levels, so inverted-logic functions may read dark
    always_comb begin
        term_w                         = DSD_WORD_ZERO;
        term_w[DSD_TW_INPUTS +: 5]     = {digital_input_three, digital_input_two,
                                          digital_input_one, backward_terminal,
                                          forward_terminal};
        term_w[DSD_TW_COMM +: 3]       = {comm_reset_cmd, comm_backward_cmd,
                                          comm_forward_cmd};
        term_w[DSD_TW_RELAY]           = relay_normally_open;
    end

    // segment image for the terminal check, unassigned segments dark
    always_comb begin
        seg_map                 = {4{DSD_SEG_DARK}};
        seg_map[0][4:0]         = term_w[DSD_TW_INPUTS +: 5];
        seg_map[1][DSD_SEG_F]   = comm_forward_cmd;
        seg_map[1][DSD_SEG_G]   = comm_backward_cmd;
        seg_map[1][DSD_SEG_DP]  = comm_reset_cmd;
        seg_map[2][DSD_SEG_A]   = transistor_output;
        seg_map[3][DSD_SEG_A]   = relay_normally_open;
    end

    // the status view is always hex; the terminal view follows the mode
    assign shown_w  = (st_r.view == DSD_VIEW_STATUS) ? stat_w : term_w;
    assign show_hex = (st_r.view == DSD_VIEW_STATUS) || (st_r.disp == DSD_DISP_HEX);

    // digit i carries nibble i, so digit 4 is bits 15..12 and digit 1 bits 3..0
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_digit
            dsd_digit_fmt u_fmt (
                .nibble   (shown_w[4*gi +: 4]),
                .hex_mode (show_hex),
                .seg_in   (seg_map[gi]),
                .seg_out  (fmt_out[gi])
            );
        end
    endgenerate

    // apb decode; zero wait states, so the answer comes in the first access cycle
    assign apb_setup  = psel && !penable;
    assign apb_access = psel && penable;
    assign addr_ok    = (paddr == DSD_ADDR_STATUS) || (paddr == DSD_ADDR_CTRL)
                     || (paddr == DSD_ADDR_LEDS)   || (paddr == DSD_ADDR_TERM);
    assign pready     = 1'b1;
    assign pslverr    = apb_access && !addr_ok;
    assign prdata     = st_r.rdata;

    // next state: status capture, mode control, digit image, read data
    always_comb begin
        st_nxt        = st_r;
        st_nxt.status = stat_w;
        st_nxt.digits = fmt_out;
        // a key toggles the terminal view between segments and hex
        if ((key_up || key_down) && st_r.view == DSD_VIEW_TERMINAL) begin
            st_nxt.disp = (st_r.disp == DSD_DISP_HEX) ? DSD_DISP_SEGMENT
                                                      : DSD_DISP_HEX;
        end
        // a software write lands after the key so that it wins a same-cycle race
        if (apb_access && pwrite && paddr == DSD_ADDR_CTRL) begin
            st_nxt.view = dsd_view_t'(pwdata[DSD_CTRL_VIEW_POS]);
            st_nxt.disp = dsd_disp_t'(pwdata[DSD_CTRL_HEX_POS]);
        end
        // read data is fetched in the setup cycle and held through the access
        if (apb_setup) begin
            case (paddr)
                DSD_ADDR_STATUS: st_nxt.rdata = {16'h0000, stat_w};
                DSD_ADDR_CTRL:   st_nxt.rdata = {30'h0, st_r.disp, st_r.view};
                DSD_ADDR_LEDS:   st_nxt.rdata = st_r.digits;
                DSD_ADDR_TERM:   st_nxt.rdata = {16'h0000, term_w};
                default:         st_nxt.rdata = 32'h00000000;
            endcase
        end
    end

    // single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r.status <= DSD_WORD_ZERO;
            st_r.view   <= dsd_view_t'(DSD_CTRL_RESET[DSD_CTRL_VIEW_POS]);
            st_r.disp   <= dsd_disp_t'(DSD_CTRL_RESET[DSD_CTRL_HEX_POS]);
            st_r.digits <= {4{DSD_SEG_DARK}};
            st_r.rdata  <= 32'h00000000;
        end else begin
            st_r <= st_nxt;
        end
    end

    // digits leave straight from the register
    assign led_digit_1 = st_r.digits[0];
    assign led_digit_2 = st_r.digits[1];
    assign led_digit_3 = st_r.digits[2];
    assign led_digit_4 = st_r.digits[3];

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_busy_bit: assert property (##1 st_r.status[DSD_ST_BUSY] == $past(param_write_busy))
        else $error("busy bit does not follow parameter write");
    a_zero_bits: assert property (st_r.status[14:13] == 2'h0 && !st_r.status[6]
                                  && !st_r.status[4])
        else $error("reserved status bits not zero");
    a_comms_bit: assert property (comms_control_active |=> st_r.status[DSD_ST_COMMS])
        else $error("comms bit missing");
    a_alarm_bit: assert property (alarm_flag |=> st_r.status[DSD_ST_ALARM])
        else $error("alarm bit missing");
    a_motion_bits: assert property (##1 st_r.status[10:8] ==
                       $past({slowing_down, speeding_up, current_limiting}))
        else $error("motion bits wrong");
    a_vctl_bit: assert property (voltage_control_active |=> st_r.status[DSD_ST_VCTL])
        else $error("voltage control bit missing");
    a_link_bit: assert property (!link_voltage_ok |=> !st_r.status[DSD_ST_LINKOK])
        else $error("link ok bit set during undervoltage");
    a_shut_brake: assert property (##1 st_r.status[3:2] ==
                       $past({output_shutdown, dc_braking_active}))
        else $error("shutdown or braking bit wrong");
    a_run_dir: assert property (##1 st_r.status[1:0] ==
                       $past({backward_run, forward_run}))
        else $error("run direction bits wrong");

    // bit 13 is forced low, so a fixed top nibble like A could never be seen;
    // compare against whatever word stood one edge earlier instead
    sequence s_hex_status;
        st_r.view == DSD_VIEW_STATUS;
    endsequence
    a_hex_glyph: assert property (s_hex_status |=>
                       led_digit_4 == DSD_GLYPH[$past(stat_w[15:12])]
                       && led_digit_1 == DSD_GLYPH[$past(stat_w[3:0])])
        else $error("hex digit glyph or order wrong");

    a_hex_middle: assert property (s_hex_status |=>
                       led_digit_3 == DSD_GLYPH[$past(stat_w[11:8])]
                       && led_digit_2 == DSD_GLYPH[$past(stat_w[7:4])])
        else $error("middle hex digits wrong");

    // terminal check in hex shows the terminal word the same way
    sequence s_term_hex;
        st_r.view == DSD_VIEW_TERMINAL ##0 st_r.disp == DSD_DISP_HEX;
    endsequence
    a_term_hex: assert property (s_term_hex |=>
                       led_digit_1 == DSD_GLYPH[$past(term_w[3:0])]
                       && led_digit_3 == DSD_GLYPH[$past(term_w[11:8])])
        else $error("terminal hex digits wrong");

    a_term_relay: assert property (s_term_hex |=>
                       led_digit_3 == DSD_GLYPH[{3'h0, $past(relay_normally_open)}])
        else $error("relay level missing from terminal word");

    sequence s_seg_view;
        st_r.view == DSD_VIEW_TERMINAL ##0 st_r.disp == DSD_DISP_SEGMENT;
    endsequence
    a_seg_inputs: assert property (s_seg_view |=> led_digit_1[4:0] ==
                       $past(term_w[4:0]) && led_digit_1[7:5] == 3'h0)
        else $error("input terminal segments wrong");
    a_seg_outputs: assert property (s_seg_view |=>
                       led_digit_3 == {7'h00, $past(transistor_output)}
                       && led_digit_4 == {7'h00, $past(relay_normally_open)})
        else $error("output terminal segments wrong");
    a_seg_comm: assert property (s_seg_view |=> led_digit_2 ==
                       {$past(comm_reset_cmd), $past(comm_backward_cmd),
                        $past(comm_forward_cmd), 5'h00})
        else $error("comm command segments wrong");
    a_key_toggle: assert property ((key_up || key_down) && st_r.view == DSD_VIEW_TERMINAL
                       && !(apb_access && pwrite) |=> st_r.disp != $past(st_r.disp))
        else $error("key did not toggle display mode");

    // keys are meant for the terminal check only; the status view ignores them
    a_key_ignored: assert property ((key_up || key_down) && st_r.view == DSD_VIEW_STATUS
                       && !(apb_access && pwrite) |=> st_r.disp == $past(st_r.disp))
        else $error("key changed display mode in status view");

    // a control write lands at the access edge and wins over a key
    sequence s_ctrl_write;
        apb_access ##0 pwrite && paddr == DSD_ADDR_CTRL;
    endsequence
    a_ctrl_write: assert property (s_ctrl_write |=>
                       st_r.view == dsd_view_t'($past(pwdata[DSD_CTRL_VIEW_POS]))
                       && st_r.disp == dsd_disp_t'($past(pwdata[DSD_CTRL_HEX_POS])))
        else $error("control write did not land");

    // bus answer: no wait states, error only in the access cycle of a hole
    a_pready_high: assert property (pready)
        else $error("ready dropped");

    a_slverr_idle: assert property (!apb_access |-> !pslverr)
        else $error("error outside access cycle");

    a_slverr_hole: assert property (apb_access && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned address not refused");

    // read data is fetched in the setup cycle from the live sources
    sequence s_read_status;
        apb_setup ##0 paddr == DSD_ADDR_STATUS;
    endsequence
    a_read_status: assert property (s_read_status |=>
                       prdata == {16'h0000, $past(stat_w)})
        else $error("status read data wrong");

    a_read_term: assert property (apb_setup && paddr == DSD_ADDR_TERM |=>
                       prdata == {16'h0000, $past(term_w)})
        else $error("terminal read data wrong");

    a_read_ctrl: assert property (apb_setup && paddr == DSD_ADDR_CTRL |=>
                       prdata[1:0] == {$past(st_r.disp), $past(st_r.view)}
                       && prdata[31:2] == 30'h0)
        else $error("control read data wrong");

    a_read_hole: assert property (apb_setup && !addr_ok |=> prdata == 32'h00000000)
        else $error("unmapped read not zero");

    // unassigned segments stay dark: segment f of the input digit and all but segment a of the third digit
    a_seg_apart: assert property (s_seg_view |=>
                       led_digit_1[DSD_SEG_F] == 1'b0 && led_digit_3[7:1] == 7'h00)
        else $error("unassigned segment lit");

endmodule : dsd_status_display
`default_nettype wire

//--- dsd_led_monitor.sv
// keypad led monitor model: reads four lit digit images back as a hex word
`timescale 1ns/1ps
`default_nettype none
module dsd_led_monitor (
    // lit segment images, digit 4 leftmost
    input  wire logic [7:0]  digit_1,
    input  wire logic [7:0]  digit_2,
    input  wire logic [7:0]  digit_3,
    input  wire logic [7:0]  digit_4,
    // word as the operator reads it
    output logic      [15:0] shown_word,
    output logic             all_glyphs
);
    logic [4:0] n1;
    logic [4:0] n2;
    logic [4:0] n3;
    logic [4:0] n4;

    // an image that is no glyph reads as 5'h10, so a torn digit never passes for a value
    function automatic logic [4:0] read_glyph(input logic [7:0] s);
        case (s)
            8'h3F: return 5'h00;
            8'h06: return 5'h01;
            8'h5B: return 5'h02;
            8'h4F: return 5'h03;
            8'h66: return 5'h04;
            8'h6D: return 5'h05;
            8'h7D: return 5'h06;
            8'h07: return 5'h07;
            8'h7F: return 5'h08;
            8'h6F: return 5'h09;
            8'h77: return 5'h0A;
            8'h7C: return 5'h0B;
            8'h39: return 5'h0C;
            8'h5E: return 5'h0D;
            8'h79: return 5'h0E;
            8'h71: return 5'h0F;
            default: return 5'h10;
        endcase
    endfunction : read_glyph

    // decode each digit on its own
    always_comb begin
        n1 = read_glyph(digit_1);
        n2 = read_glyph(digit_2);
        n3 = read_glyph(digit_3);
        n4 = read_glyph(digit_4);
    end

    // leftmost digit is the top nibble
    assign shown_word = {n4[3:0], n3[3:0], n2[3:0], n1[3:0]};
    assign all_glyphs = !(n1[4] | n2[4] | n3[4] | n4[4]);
endmodule : dsd_led_monitor
`default_nettype wire

//--- drive_status_display_encoder_tb.sv
// testbench of the drive status display encoder
`timescale 1ns/1ps
`default_nettype none
module drive_status_display_encoder_tb import dsd_pkg::*;;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        key_up, key_down, err, glyph_ok;
    logic [7:0]  paddr, d1, d2, d3, d4;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] flags, shown;
    logic [6:0]  terms;
    logic [2:0]  cmds;
    int          errors, n_tests, i;

    dsd_status_display dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .param_write_busy(flags[15]), .comms_control_active(flags[12]),
        .alarm_flag(flags[11]), .slowing_down(flags[10]), .speeding_up(flags[9]),
        .current_limiting(flags[8]), .voltage_control_active(flags[7]),
        .link_voltage_ok(flags[5]), .output_shutdown(flags[3]),
        .dc_braking_active(flags[2]), .backward_run(flags[1]), .forward_run(flags[0]),
        .forward_terminal(terms[0]), .backward_terminal(terms[1]),
        .digital_input_one(terms[2]), .digital_input_two(terms[3]),
        .digital_input_three(terms[4]), .transistor_output(terms[5]),
        .relay_normally_open(terms[6]), .comm_forward_cmd(cmds[0]),
        .comm_backward_cmd(cmds[1]), .comm_reset_cmd(cmds[2]),
        .key_up(key_up), .key_down(key_down), .led_digit_1(d1), .led_digit_2(d2),
        .led_digit_3(d3), .led_digit_4(d4)
    );

    dsd_led_monitor mon_u (
        .digit_1(d1), .digit_2(d2), .digit_3(d3), .digit_4(d4),
        .shown_word(shown), .all_glyphs(glyph_ok)
    );

    // free-running 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    // one apb transfer; the request stands until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 16) begin
            errors++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // one-cycle key pulse, then time for the digits to settle
    task automatic press(input logic up);
        @(posedge pclk);
        key_up <= up;
        key_down <= !up;
        @(posedge pclk);
        key_up <= 1'b0;
        key_down <= 1'b0;
        tick(3);
    endtask : press

    // expected segment image {digit4, digit3, digit2, digit1}
    function automatic logic [31:0] seg_img(input logic [2:0] c, input logic [6:0] t);
        return {7'h00, t[6], 7'h00, t[5], c, 5'h00, 3'h0, t[4:0]};
    endfunction : seg_img

    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, key_up, key_down} = 6'h00;
        {paddr, pwdata, flags, terms, cmds} = '0;
        errors = 0;
        n_tests = 0;
        tick(8);
        presetn <= 1'b1;
        apb(1'b0, DSD_ADDR_CTRL, 32'h0);
        check("ctrl reset", rd, 32'h0);
        apb(1'b0, DSD_ADDR_STATUS, 32'h0);
        check("status undervoltage", rd, 32'h0);
        // one flag at a time over all sixteen positions; four of them must stay zero
        for (i = 0; i < 16; i++) begin
            flags <= 16'h0001 << i;
            tick(3);
            apb(1'b0, DSD_ADDR_STATUS, 32'h0);
            check("status bit", rd, {16'h0000, (16'h0001 << i) & 16'h9FAF});
            check("shown status", {16'h0000, shown}, rd);
        end
        // every nibble value through the third digit
        for (i = 0; i < 16; i++) begin
            flags <= {4'h0, i[3:0], 8'h00};
            tick(3);
            check("glyph", {16'h0000, shown}, {20'h00000, i[3:0], 8'h00});
            check("glyph valid", {31'h0, glyph_ok}, 32'h1);
        end
        flags <= 16'hFFFF;
        tick(3);
        apb(1'b0, DSD_ADDR_STATUS, 32'h0);
        check("status all", rd, 32'h9FAF);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        apb(1'b1, DSD_ADDR_STATUS, 32'hFFFF_0000);
        check("ro write error", {31'h0, err}, 32'h0);
        apb(1'b0, DSD_ADDR_STATUS, 32'h0);
        check("ro write ignored", rd, 32'h9FAF);
        // terminal check, segment display: each terminal alone, then all together
        apb(1'b1, DSD_ADDR_CTRL, 32'h1);
        for (i = 0; i < 11; i++) begin
            {cmds, terms} <= (i < 10) ? (10'h001 << i) : 10'h3FF;
            tick(3);
            check("segments", {d4, d3, d2, d1}, seg_img(cmds, terms));
        end
        apb(1'b0, DSD_ADDR_LEDS, 32'h0);
        check("led image", rd, seg_img(3'h7, 7'h7F));
        // keys switch the terminal check between segments and hex
        terms <= 7'h45;
        cmds <= 3'h2;
        press(1'b1);
        check("terminal hex", {16'h0000, shown}, 32'h0145);
        apb(1'b0, DSD_ADDR_CTRL, 32'h0);
        check("ctrl hex", rd, 32'h3);
        press(1'b0);
        check("back to segments", {d4, d3, d2, d1}, seg_img(3'h2, 7'h45));
        // keys do nothing in the running status view
        apb(1'b1, DSD_ADDR_CTRL, 32'h0);
        press(1'b1);
        apb(1'b0, DSD_ADDR_CTRL, 32'h0);
        check("key ignored", rd, 32'h0);
        complete_run();
    end
endmodule : drive_status_display_encoder_tb
`default_nettype wire
